// file: inc/conv_ctrl_pkg.sv
// Package for the converter output control block: widths, latency,
// coding constants and Avalon-MM register map.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package conv_ctrl_pkg;
   // ==========================================================
   // Data path
   localparam int DATA_W = 12;
   localparam int PIPE_DEPTH = 5;
   localparam int FIFO_DEPTH = 16;
   localparam int MSB_POS = 11;
   // ==========================================================
   // Register map (byte addresses, 32-bit words)
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam logic [3:0] COUNT_ADDR = 4'h8;
   // Control field positions
   localparam int CTRL_OE_N_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CTRL_TWOS_BIT = 2;
   // Status field positions
   localparam int STAT_SLEEP_BIT = 0;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_OVR_BIT = 2;
   localparam int STAT_OVR_SEEN_BIT = 3;
   // Control reset: outputs disabled, awake, offset binary
   localparam logic [2:0] CTRL_RESET = 3'h1;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// file: rtl/sample_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module sample_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in,
   // Occupancy
   output logic [$clog2(DEPTH):0] level_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // ==========================================================
   // Handshakes
   assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_q[rd_q];
   assign level_out = cnt_q;

   // Storage, no reset needed on the data words
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end
endmodule

// file: rtl/conv_output_ctrl.sv
// Output control of a pipelined 12-bit converter: pipeline alignment of
// data and over-range flag, coding select, sleep and output enable.
// Assumes raw samples arrive once per clock, synchronous to ref_clk_in.
//
// Operation
// - Drive data outputs while enable low; release them while high.
// - Sleep request high enters power-down; reference stays active.
// - Power-down flushes pipeline; valid data only after full latency.
// - Flag low when in range, high when sample exceeded range.
// - Flag travels with its data word, six-clock latency.
// - Select high gives two's complement; low gives offset binary.
`timescale 1ns/1ns
module conv_output_ctrl #(
   parameter int DATA_W = conv_ctrl_pkg::DATA_W,
   parameter int PIPE_DEPTH = conv_ctrl_pkg::PIPE_DEPTH,
   parameter int FIFO_DEPTH = conv_ctrl_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Raw samples from the quantiser, offset binary
   input wire logic [DATA_W-1:0] raw_sample_in,
   input wire logic raw_over_range_in,
   // Pin-level controls
   input wire logic output_enable_n_in,
   input wire logic sleep_request_in,
   input wire logic twos_complement_select_in,
   // Parallel data pins, two signals each (data and enable)
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe_out,
   output logic over_range_flag_out,
   output logic sleep_active_out,
   // Buffered stream for on-chip consumer
   output logic stream_valid_out,
   output logic [DATA_W:0] stream_data_out,
   input wire logic stream_ready_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int CW = $clog2(PIPE_DEPTH + 1);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   logic [DATA_W-1:0] pipe_data_q [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] pipe_ovr_q;
   logic [PIPE_DEPTH-1:0] pipe_vld_q;
   logic [2:0] ctrl_q;
   logic sleep_q;
   logic ovr_seen_q;
   logic [31:0] word_cnt_q;
   logic [CW-1:0] fill_q;
   logic sleep_eff;
   logic twos_eff;
   logic oe_n_eff;
   logic [DATA_W-1:0] coded;
   logic out_vld;
   logic fifo_in_ready;
   logic fifo_valid;
   logic [DATA_W:0] fifo_data;
   logic [LW-1:0] fifo_level;
   logic ack_q;

   // ==========================================================
   // Control combining pins and software bits
   // Either source may request sleep or disable the drivers
   assign sleep_eff = sleep_request_in | ctrl_q[conv_ctrl_pkg::CTRL_SLEEP_BIT];
   assign oe_n_eff = output_enable_n_in
                     | ctrl_q[conv_ctrl_pkg::CTRL_OE_N_BIT];
   assign twos_eff = twos_complement_select_in
                     | ctrl_q[conv_ctrl_pkg::CTRL_TWOS_BIT];
   assign out_vld = pipe_vld_q[PIPE_DEPTH-1];

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_eff;
      end
   end

   // ==========================================================
   // Conversion pipeline
   // Data and flag shift in two parallel chains of equal depth
   genvar g;
   generate
      for (g = 0; g < PIPE_DEPTH; g++) begin : g_pipe
         // Head stage split off so no stage ever names index -1
         if (g == 0) begin : g_head
            always_ff @(posedge ref_clk_in) begin
               pipe_data_q[g] <= raw_sample_in;
            end
         end else begin : g_body
            always_ff @(posedge ref_clk_in) begin
               pipe_data_q[g] <= pipe_data_q[g-1];
            end
         end
      end
   endgenerate

   // Flag chain, low when in range
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pipe_ovr_q <= '0;
      end else begin
         pipe_ovr_q <= {pipe_ovr_q[PIPE_DEPTH-2:0], raw_over_range_in};
      end
   end

   // Sleep flushes the valid chain so stale words never emerge
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || sleep_eff) begin
         pipe_vld_q <= '0;
      end else begin
         pipe_vld_q <= {pipe_vld_q[PIPE_DEPTH-2:0], 1'b1};
      end
   end

   // Fill count after wake; status shows only whether it has reached PIPE_DEPTH
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || sleep_eff) begin
         fill_q <= '0;
      end else if (fill_q != CW'(PIPE_DEPTH)) begin
         fill_q <= fill_q + CW'(1);
      end
   end

   // ==========================================================
   // Output coding and pins
   // Two's complement is offset binary with the MSB inverted
   always_comb begin
      coded = pipe_data_q[PIPE_DEPTH-1];
      if (twos_eff) begin
         coded[conv_ctrl_pkg::MSB_POS] = ~coded[conv_ctrl_pkg::MSB_POS];
      end
   end

   // One word per clock; invalid words read as zero
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         data_out <= '0;
         over_range_flag_out <= 1'b0;
      end else begin
         data_out <= out_vld ? coded : '0;
         over_range_flag_out <= out_vld & pipe_ovr_q[PIPE_DEPTH-1];
      end
   end

   // Drivers on only while enable is low
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         data_oe_out <= '0;
      end else begin
         data_oe_out <= {DATA_W{~oe_n_eff}};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         sleep_active_out <= 1'b0;
      end else begin
         sleep_active_out <= sleep_eff;
      end
   end

   // ==========================================================
   // Buffered stream; a full FIFO drops words, counted below
   sample_fifo #(
      .WIDTH(DATA_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .in_valid_in(out_vld),
      .in_data_in({pipe_ovr_q[PIPE_DEPTH-1], coded}),
      .in_ready_out(fifo_in_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(stream_ready_in),
      .level_out(fifo_level)
   );

   // Unregistered skid-free view: present head, advance on accept
   assign stream_valid_out = fifo_valid;
   assign stream_data_out = fifo_data;

   // Sticky over-range seen; a new event wins over the clear
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ovr_seen_q <= 1'b0;
      end else if (out_vld && pipe_ovr_q[PIPE_DEPTH-1]) begin
         ovr_seen_q <= 1'b1;
      end else if (avs_write && !avs_waitrequest
                   && avs_address == conv_ctrl_pkg::STATUS_ADDR
                   && avs_writedata[conv_ctrl_pkg::STAT_OVR_SEEN_BIT]) begin
         ovr_seen_q <= 1'b0;
      end
   end

   // Words lost to a full FIFO, the back-pressure symptom
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         word_cnt_q <= '0;
      end else if (out_vld && !fifo_in_ready) begin
         word_cnt_q <= word_cnt_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // Avalon-MM slave: one wait cycle, answer on the second
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Control register write
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= conv_ctrl_pkg::CTRL_RESET;
      end else if (avs_write && ack_q
                   && avs_address == conv_ctrl_pkg::CTRL_ADDR) begin
         ctrl_q <= avs_writedata[2:0];
      end
   end

   // Read data, prepared during the wait cycle
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         avs_readdata <= '0;
      end else if (avs_address == conv_ctrl_pkg::CTRL_ADDR) begin
         avs_readdata <= {29'h0000_0000, ctrl_q};
      end else if (avs_address == conv_ctrl_pkg::STATUS_ADDR) begin
         avs_readdata <= {20'h0_0000, 3'h0, fifo_level[LW-1:0],
                          ovr_seen_q, over_range_flag_out,
                          (fill_q == CW'(PIPE_DEPTH)), sleep_q};
      end else if (avs_address == conv_ctrl_pkg::COUNT_ADDR) begin
         avs_readdata <= word_cnt_q;
      end else begin
         avs_readdata <= conv_ctrl_pkg::UNMAPPED_DATA;
      end
   end
endmodule

// file: testbench/conv_ctrl_chk.sv
// Port checker for conv_output_ctrl, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module conv_ctrl_chk #(
   parameter int DATA_W = 12
) (
   // Watched ports
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [DATA_W-1:0] raw_sample_in,
   input wire logic raw_over_range_in,
   input wire logic output_enable_n_in,
   input wire logic sleep_request_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic [DATA_W-1:0] data_oe_out,
   input wire logic over_range_flag_out,
   input wire logic sleep_active_out,
   input wire logic stream_valid_out,
   input wire logic [DATA_W:0] stream_data_out,
   input wire logic stream_ready_in,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   logic [3:0] warm_q;
   // ==========================================
   // Clean cycles since reset or sleep; alignment needs a full refill
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || sleep_request_in || sleep_active_out) begin
         warm_q <= 4'h0;
      end else if (warm_q != 4'hF) begin
         warm_q <= warm_q + 4'h1;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   oe_release_a: assert property (
      output_enable_n_in [*2] |-> data_oe_out == '0)
      else $error("pins driven while disabled");
   oe_uniform_a: assert property (
      data_oe_out == '0 || data_oe_out == '1)
      else $error("mixed pin enables");
   sleep_enter_a: assert property (
      sleep_request_in [*2] |-> sleep_active_out)
      else $error("sleep request ignored");
   sleep_flush_a: assert property (
      sleep_active_out [*2] |-> data_out == '0)
      else $error("data shown while asleep");
   wake_refill_a: assert property (
      $fell(sleep_active_out) |-> (data_out == '0) [*4])
      else $error("stale data after wake");
   flag_align_a: assert property (
      warm_q >= 4'h9 |->
      over_range_flag_out == $past(raw_over_range_in, 6))
      else $error("flag not aligned with its word");
   data_align_a: assert property (
      warm_q >= 4'h9 |->
      data_out[DATA_W-2:0] == $past(raw_sample_in[DATA_W-2:0], 6))
      else $error("word not aligned");
   stream_hold_a: assert property (
      stream_valid_out && !stream_ready_in |=>
      stream_valid_out && $stable(stream_data_out))
      else $error("stream head changed while stalled");
   wait_one_a: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait");
endmodule
bind conv_output_ctrl conv_ctrl_chk #(.DATA_W(DATA_W)) chk_u (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
   .raw_sample_in(raw_sample_in), .raw_over_range_in(raw_over_range_in),
   .output_enable_n_in(output_enable_n_in),
   .sleep_request_in(sleep_request_in), .data_out(data_out),
   .data_oe_out(data_oe_out), .over_range_flag_out(over_range_flag_out),
   .sleep_active_out(sleep_active_out), .stream_valid_out(stream_valid_out),
   .stream_data_out(stream_data_out), .stream_ready_in(stream_ready_in),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest));

// file: testbench/sample_sink.sv
// Downstream logic model: captures pin words, drains the stream.
// Assumes the bench steers stall_in after a clock edge.
`timescale 1ns/1ns
module sample_sink (
   // Clock and control
   input wire logic clk_in,
   input wire logic stall_in,
   // Pins and stream
   input wire logic [11:0] data_in,
   output logic [11:0] capt_out,
   output logic ready_out
);
   // ==========================================
   // one capture per clock
   always @(posedge clk_in) begin
      capt_out <= data_in;
      ready_out <= !stall_in && 1'($urandom);
   end
endmodule

// file: testbench/conv_output_ctrl_tb_top.sv
// Self-checking bench for conv_output_ctrl against a queue model.
// Assumes package, FIFO and checker are compiled first.
`timescale 1ns/1ns
module conv_output_ctrl_tb_top;
   // ==========================================
   // Pins and model state
   localparam int LAT = conv_ctrl_pkg::PIPE_DEPTH + 1;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [11:0] raw_q = 12'h000;
   logic ovr_q = 1'b0;
   logic oe_n = 1'b0;
   logic slp = 1'b0;
   logic tw = 1'b0;
   logic stall = 1'b0;
   logic [2:0] ctl = 3'h1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, flag, sact, sv, rdy, oe_last;
   logic [11:0] dout, doe;
   logic [12:0] sdat;
   logic [12:0] hist[$];
   // Stream model: expected FIFO contents and the valid chain it is fed by
   logic [12:0] sq[$];
   logic [4:0] mv = 5'h00;
   logic rst_last = 1'b1;
   logic se_last = 1'b1;
   logic te_last = 1'b0;
   logic rdy_last = 1'b0;
   logic ovr_en = 1'b1;
   int err_total = 0, n_compared = 0, wc = 0, sc = 0, oc = 0, cyc = 0;
   int nb = 0;
   conv_output_ctrl dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .raw_sample_in(raw_q), .raw_over_range_in(ovr_q),
      .output_enable_n_in(oe_n), .sleep_request_in(slp),
      .twos_complement_select_in(tw), .data_out(dout), .data_oe_out(doe),
      .over_range_flag_out(flag), .sleep_active_out(sact),
      .stream_valid_out(sv), .stream_data_out(sdat), .stream_ready_in(rdy),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   sample_sink sink_u (.clk_in(ref_clk_in), .stall_in(stall),
      .data_in(dout), .capt_out(), .ready_out(rdy));
   always #4 ref_clk_in = ~ref_clk_in;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bus cycle held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
      @(posedge ref_clk_in);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      // Only the bench timeout may end this wait
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wctl(input logic [2:0] v);
      bus(1'b1, conv_ctrl_pkg::CTRL_ADDR, 32'(v));
      ctl = v;
   endtask
   // ==========================================
   // Random samples, and the model checked at each falling edge
   always @(posedge ref_clk_in) begin
      raw_q <= 12'($urandom);
      ovr_q <= ovr_en & 1'($urandom);
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         tally_and_finish();
      end
   end
   always @(negedge ref_clk_in) begin
      hist.push_front({ovr_q, raw_q});
      if (hist.size() > 8)
         void'(hist.pop_back());
      wc = (sys_rst_in || slp || ctl[1]) ? 0 : wc + 1;
      sc = (!sys_rst_in && (slp || ctl[1])) ? sc + 1 : 0;
      oc = ((oe_n | ctl[0]) === oe_last) ? oc + 1 : 0;
      oe_last = oe_n | ctl[0];
      if (wc > LAT + 4) begin
         chk(32'(dout), 32'(hist[LAT][11:0] ^ {tw | ctl[2], 11'h0}));
         chk(32'(flag), 32'(hist[LAT][12]));
      end
      if (wc >= 2 && wc <= 5)
         chk(32'(dout), 32'h0);
      if (sc > 2) begin
         chk(32'(sact), 32'h1);
         chk(32'(dout), 32'h0);
      end
      if (oc > 2 && !sys_rst_in)
         chk(32'(doe), oe_last ? 32'h0 : 32'hFFF);
      // Stream: pop and push at the last edge, full FIFO drops the word
      nb = sq.size();
      if (rst_last) begin
         sq.delete();
      end else begin
         if (nb != 0 && rdy_last)
            void'(sq.pop_front());
         if (mv[4] && nb < conv_ctrl_pkg::FIFO_DEPTH)
            sq.push_back({hist[LAT][12], hist[LAT][11:0] ^ {te_last, 11'h000}});
      end
      mv = se_last ? 5'h00 : {mv[3:0], 1'b1};
      chk(32'(sv), 32'(sq.size() != 0));
      if (sq.size() != 0)
         chk(32'(sdat), 32'(sq[0]));
      // Values the design sees at the next edge
      rst_last = sys_rst_in;
      se_last = sys_rst_in || slp || ctl[1];
      te_last = tw | ctl[2];
      rdy_last = rdy;
   end
   initial begin
      void'($urandom(71619));
      repeat (5) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      bus(1'b0, conv_ctrl_pkg::CTRL_ADDR, 32'h0);
      chk(rd, 32'(conv_ctrl_pkg::CTRL_RESET));
      bus(1'b1, 4'hC, 32'h7);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, conv_ctrl_pkg::UNMAPPED_DATA);
      wctl(3'h0);
      $display("registers done");
      // enable held for many cycles, never toggled fast
      repeat (40) @(posedge ref_clk_in);
      oe_n <= 1'b1;
      repeat (20) @(posedge ref_clk_in);
      oe_n <= 1'b0;
      $display("output enable done");
      // Sticky flag: seen, then cleared while no new event arrives
      ovr_en <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      bus(1'b0, conv_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk(32'(rd[3:0]), 32'hA);
      bus(1'b1, conv_ctrl_pkg::STATUS_ADDR, 32'h8);
      bus(1'b0, conv_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk(32'(rd[3:0]), 32'h2);
      ovr_en <= 1'b1;
      $display("over-range status done");
      // both codings, chosen while the pipeline is asleep
      for (int i = 0; i < 2; i++) begin
         slp <= 1'b1;
         repeat (10) @(posedge ref_clk_in);
         tw <= !i[0];
         repeat (10) @(posedge ref_clk_in);
         slp <= 1'b0;
         repeat (40) @(posedge ref_clk_in);
      end
      $display("sleep pin done");
      // Sleep and coding through the register
      wctl(3'h6);
      repeat (10) @(posedge ref_clk_in);
      bus(1'b0, conv_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk(32'(rd[0]), 32'h1);
      wctl(3'h4);
      repeat (40) @(posedge ref_clk_in);
      // Stalled consumer: FIFO fills, then drains empty while asleep
      stall <= 1'b1;
      repeat (40) @(posedge ref_clk_in);
      bus(1'b0, conv_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk(32'(rd[8:4]), 32'(conv_ctrl_pkg::FIFO_DEPTH));
      bus(1'b0, conv_ctrl_pkg::COUNT_ADDR, 32'h0);
      chk(32'(rd != 32'h0), 32'h1);
      wctl(3'h2);
      stall <= 1'b0;
      repeat (60) @(posedge ref_clk_in);
      chk(32'(sv), 32'h0);
      wctl(3'h0);
      repeat (30) @(posedge ref_clk_in);
      $display("fifo done");
      tally_and_finish();
   end
endmodule
